//--- shared/fdd_pkg.sv
// Package with timing counts, phase codes and widths shared by both ends
package fdd_pkg;
   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 250_000_000;
   localparam int CLK_PERIOD_NS = 4;
   // Trim erase delay after write start, in microseconds
   localparam int TRIM_DELAY_US = 190;
   localparam int TRIM_DELAY_CYC = (TRIM_DELAY_US * (CLK_HZ / 1_000_000) + 0);
   // Trim erase hold after last write activity, in microseconds
   localparam int TRIM_HOLD_US = 550;
   localparam int TRIM_HOLD_CYC = TRIM_HOLD_US * (CLK_HZ / 1_000_000);
   // Index period in nanoseconds (166.667 ms) and pulse width (2.0 ms)
   localparam longint INDEX_PERIOD_NS = 166_667_000;
   localparam int INDEX_PERIOD_CYC = int'(INDEX_PERIOD_NS / CLK_PERIOD_NS);
   localparam int INDEX_WIDTH_US = 2000;
   localparam int INDEX_WIDTH_CYC = INDEX_WIDTH_US * (CLK_HZ / 1_000_000);
   // Host side step timing: pulse low 200 ns min, direction settle 100 us
   localparam int STEP_LOW_NS = 200;
   localparam int STEP_LOW_CYC = (STEP_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIR_SETTLE_US = 100;
   localparam int DIR_SETTLE_CYC = DIR_SETTLE_US * (CLK_HZ / 1_000_000);
   // Host side write strobe lead and lag around flux pulses, 2 to 4 us
   localparam int GATE_LEAD_US = 3;
   localparam int GATE_LEAD_CYC = GATE_LEAD_US * (CLK_HZ / 1_000_000);
   // Host wait after write strobe release before stepping: 1 ms
   localparam int STEP_AFTER_WRITE_US = 1000;
   localparam int STEP_AFTER_WRITE_CYC = STEP_AFTER_WRITE_US * (CLK_HZ / 1_000_000);
   // Flux half-period for the all-zero pattern (250 kbit/s -> 4 us)
   localparam int ZERO_RATE_NS = 4000;
   localparam int ZERO_RATE_CYC = ZERO_RATE_NS / CLK_PERIOD_NS;
   localparam int FLUX_LOW_CYC = 25;
   // ------------------------------------------------------------
   // Widths and codes
   // ------------------------------------------------------------
   localparam int TIMER_W = 26;
   localparam int REG_ADDR_W = 2;
   localparam logic [1:0] PHASE_0 = 2'h0;
   localparam logic [1:0] PHASE_1 = 2'h1;
   localparam logic [1:0] PHASE_2 = 2'h3;
   localparam logic [1:0] PHASE_3 = 2'h2;
   // Host register offsets
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_CMD = 2'h1;
   localparam logic [1:0] REG_STATUS = 2'h2;
   localparam logic [1:0] REG_FLUX = 2'h3;
   // Control register bit positions
   localparam int CTRL_SELECT = 0;
   localparam int CTRL_SIDE1 = 1;
   localparam int CTRL_REDUCED = 2;
   // Command register bit positions
   localparam int CMD_STEP = 0;
   localparam int CMD_DIR_OUT = 1;
   localparam int CMD_WRITE = 2;
   localparam int CMD_STOP = 3;
   // Host sequencer states, Gray along the usual path
   typedef enum logic [2:0] {
      H_IDLE = 3'h0,
      H_DIR = 3'h1,
      H_STEP = 3'h3,
      H_HOLD = 3'h2,
      H_LEAD = 3'h6,
      H_WRITE = 3'h7,
      H_LAG = 3'h5,
      H_QUIET = 3'h4
   } host_state_type;
endpackage : fdd_pkg

//--- shared/fdd_if.sv
// Interface carrying the parallel drive cable between host and drive
interface fdd_if;
   logic select_n;
   logic dir_out;
   logic step_n;
   logic head_write_strobe_n;
   logic flux_pulse_input_n;
   logic reduced_current_n;
   logic side_select_n;
   logic index_n;
   logic write_protect_n;
   modport drive (
      input select_n, dir_out, step_n, head_write_strobe_n, flux_pulse_input_n,
      input reduced_current_n, side_select_n,
      output index_n, write_protect_n
   );
   modport host (
      output select_n, dir_out, step_n, head_write_strobe_n, flux_pulse_input_n,
      output reduced_current_n, side_select_n,
      input index_n, write_protect_n
   );
endinterface : fdd_if

//--- verilog/sync_fall.sv
// Two-flop synchroniser with falling and rising edge pulses decoded from sync_reg and last_reg
module sync_fall #(
   parameter logic RESET_VALUE = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic async_in,
   output logic level,
   output logic fell,
   output logic rose
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;
   // Only sync_reg reads meta_reg
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= RESET_VALUE;
         sync_reg <= RESET_VALUE;
         last_reg <= RESET_VALUE;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end
   assign level = sync_reg;
   assign fell = last_reg & ~sync_reg;
   assign rose = ~last_reg & sync_reg;
endmodule : sync_fall

//--- verilog/fdd_drive.sv
// Drive end: stepper phase sequencer, write path, trim erase and index timing
module fdd_drive (
   input wire logic clk,
   input wire logic rst,
   fdd_if.drive cable,
   input wire logic media_protected,
   output logic [1:0] phase,
   output logic write_current_on,
   output logic full_current,
   output logic winding_select,
   output logic trim_erase_on,
   output logic read_enable,
   output logic side1_selected
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic sel_n_s;
   logic dir_s;
   logic step_n_s;
   logic step_rose;
   logic gate_n_s;
   logic gate_fell;
   logic gate_rose;
   logic flux_fell;
   logic reduced_n_s;
   logic side_n_s;
   sync_fall #(.RESET_VALUE(1'b1)) u_sel (.clk(clk), .rst(rst), .async_in(cable.select_n),
      .level(sel_n_s), .fell(), .rose());
   sync_fall #(.RESET_VALUE(1'b1)) u_dir (.clk(clk), .rst(rst), .async_in(cable.dir_out),
      .level(dir_s), .fell(), .rose());
   sync_fall #(.RESET_VALUE(1'b1)) u_step (.clk(clk), .rst(rst), .async_in(cable.step_n),
      .level(step_n_s), .fell(), .rose(step_rose));
   sync_fall #(.RESET_VALUE(1'b1)) u_gate (.clk(clk), .rst(rst),
      .async_in(cable.head_write_strobe_n), .level(gate_n_s), .fell(gate_fell),
      .rose(gate_rose));
   sync_fall #(.RESET_VALUE(1'b1)) u_flux (.clk(clk), .rst(rst),
      .async_in(cable.flux_pulse_input_n), .level(), .fell(flux_fell), .rose());
   sync_fall #(.RESET_VALUE(1'b1)) u_red (.clk(clk), .rst(rst),
      .async_in(cable.reduced_current_n), .level(reduced_n_s), .fell(), .rose());
   sync_fall #(.RESET_VALUE(1'b1)) u_side (.clk(clk), .rst(rst),
      .async_in(cable.side_select_n), .level(side_n_s), .fell(), .rose());
   logic prot_m_reg;
   logic prot_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prot_m_reg <= 1'b1;
         prot_reg <= 1'b1;
      end else begin
         prot_m_reg <= media_protected;
         prot_reg <= prot_m_reg;
      end
   end
   // ------------------------------------------------------------
   // Stepper phase sequencer
   // ------------------------------------------------------------
   logic [1:0] phase_reg;
   logic step_ok;
   logic toggle_hi;
   logic [1:0] phase_next;
   // Selected and not writing gate the step pulse
   assign step_ok = step_rose & ~sel_n_s & gate_n_s;
   // XOR of direction with phase bits picks the bit to flip
   assign toggle_hi = dir_s ^ phase_reg[1] ^ phase_reg[0];
   assign phase_next = toggle_hi ? {~phase_reg[1], phase_reg[0]}
                                 : {phase_reg[1], ~phase_reg[0]};
   // Phase register, cleared to phase zero at power-up
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_reg <= fdd_pkg::PHASE_0;
      end else if (step_ok) begin
         phase_reg <= phase_next;
      end
   end
   // ------------------------------------------------------------
   // Write path
   // ------------------------------------------------------------
   logic write_en;
   logic winding_reg;
   assign write_en = ~gate_n_s & ~prot_reg & ~sel_n_s;
   // Winding flip-flop flips on each falling flux edge while writing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         winding_reg <= 1'b0;
      end else if (write_en & flux_fell) begin
         winding_reg <= ~winding_reg;
      end
   end
   // ------------------------------------------------------------
   // Trim erase timers
   // ------------------------------------------------------------
   logic [fdd_pkg::TIMER_W-1:0] delay_reg;
   logic [fdd_pkg::TIMER_W-1:0] hold_reg;
   logic delay_done;
   logic hold_active;
   logic write_tran;
   assign write_tran = write_en & flux_fell;
   // Delay counts from strobe start; done once interval elapsed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         delay_reg <= '0;
      end else if (gate_fell | gate_n_s) begin
         delay_reg <= '0;
      end else if (delay_reg != fdd_pkg::TIMER_W'(fdd_pkg::TRIM_DELAY_CYC)) begin
         delay_reg <= delay_reg + 1'b1;
      end
   end
   // Gated by write enable so erase cannot start on protected or deselected media
   assign delay_done = write_en & (delay_reg == fdd_pkg::TIMER_W'(fdd_pkg::TRIM_DELAY_CYC));
   // Hold retriggers on strobe and transitions, then runs out
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_reg <= '0;
      end else if (~gate_n_s | gate_rose | write_tran) begin
         hold_reg <= fdd_pkg::TIMER_W'(fdd_pkg::TRIM_HOLD_CYC);
      end else if (hold_reg != '0) begin
         hold_reg <= hold_reg - 1'b1;
      end
   end
   assign hold_active = (hold_reg != '0);
   // Delay latch: keeps erase on through the tail after strobe release
   logic delay_seen_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         delay_seen_reg <= 1'b0;
      end else if (delay_done & ~prot_reg & ~sel_n_s) begin
         delay_seen_reg <= 1'b1;
      end else if (~hold_active | gate_fell) begin
         delay_seen_reg <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // Index timing
   // ------------------------------------------------------------
   logic [fdd_pkg::TIMER_W-1:0] rev_reg;
   logic rev_wrap;
   assign rev_wrap = (rev_reg == fdd_pkg::TIMER_W'(fdd_pkg::INDEX_PERIOD_CYC - 1));
   // Revolution counter; index low for first part of each turn
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rev_reg <= '0;
      end else begin
         rev_reg <= rev_wrap ? '0 : rev_reg + 1'b1;
      end
   end
   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   logic index_n_reg;
   logic wp_n_reg;
   logic wcur_reg;
   logic full_reg;
   logic trim_reg;
   logic side1_reg;
   logic read_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         read_reg <= 1'b1;
         index_n_reg <= 1'b1;
         wp_n_reg <= 1'b1;
         wcur_reg <= 1'b0;
         full_reg <= 1'b1;
         trim_reg <= 1'b0;
         side1_reg <= 1'b0;
      end else begin
         index_n_reg <= ~(rev_reg < fdd_pkg::TIMER_W'(fdd_pkg::INDEX_WIDTH_CYC));
         wp_n_reg <= ~(prot_reg & ~sel_n_s);
         wcur_reg <= write_en;
         read_reg <= ~write_en;
         full_reg <= reduced_n_s;
         trim_reg <= (delay_done | delay_seen_reg) & hold_active;
         side1_reg <= ~side_n_s;
      end
   end
   assign cable.index_n = index_n_reg;
   assign cable.write_protect_n = wp_n_reg;
   assign phase = phase_reg;
   assign write_current_on = wcur_reg;
   assign full_current = full_reg;
   assign winding_select = winding_reg;
   assign trim_erase_on = trim_reg;
   assign read_enable = read_reg;
   assign side1_selected = side1_reg;
endmodule : fdd_drive

//--- verilog/fdd_host.sv
// Host end: command registers driving step and write sequences on the cable
//
// The placing of the registers and strobed register access are this design's own decisions.
module fdd_host (
   input wire logic clk,
   input wire logic rst,
   fdd_if.host cable,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic idx_fell;
   logic wp_n_s;
   sync_fall #(.RESET_VALUE(1'b1)) u_idx (.clk(clk), .rst(rst), .async_in(cable.index_n),
      .level(), .fell(idx_fell), .rose());
   sync_fall #(.RESET_VALUE(1'b1)) u_wp (.clk(clk), .rst(rst),
      .async_in(cable.write_protect_n), .level(wp_n_s), .fell(), .rose());
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [2:0] ctrl_reg;
   logic [7:0] flux_count_reg;
   logic [7:0] rdata_reg;
   logic index_seen_reg;
   logic [3:0] cmd_reg;
   logic cmd_pend_reg;
   fdd_pkg::host_state_type state_reg;
   fdd_pkg::host_state_type state_next;
   logic [fdd_pkg::TIMER_W-1:0] cnt_reg;
   logic busy;
   logic wr_ctrl;
   logic wr_cmd;
   logic wr_flux;
   logic [7:0] rd_mux;
   assign busy = (state_reg != fdd_pkg::H_IDLE) | cmd_pend_reg;
   assign wr_ctrl = reg_write & (reg_addr == fdd_pkg::REG_CTRL);
   assign wr_cmd = reg_write & (reg_addr == fdd_pkg::REG_CMD) & ~busy;
   assign wr_flux = reg_write & (reg_addr == fdd_pkg::REG_FLUX) & ~busy;
   assign rd_mux = (reg_addr == fdd_pkg::REG_CTRL) ? {5'h00, ctrl_reg} :
                   (reg_addr == fdd_pkg::REG_STATUS) ?
                      {5'h00, ~wp_n_s, index_seen_reg, busy} :
                   (reg_addr == fdd_pkg::REG_FLUX) ? flux_count_reg : 8'h00;
   // Register writes, index flag (set wins over read-clear) and read data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= 3'h0;
         rdata_reg <= 8'h00;
         index_seen_reg <= 1'b0;
      end else begin
         if (wr_ctrl & ~(state_reg == fdd_pkg::H_WRITE)) begin
            ctrl_reg <= reg_wdata[2:0];
         end
         rdata_reg <= reg_read ? rd_mux : 8'h00;
         if (idx_fell) begin
            index_seen_reg <= 1'b1;
         end else if (reg_read & (reg_addr == fdd_pkg::REG_STATUS)) begin
            index_seen_reg <= 1'b0;
         end
      end
   end
   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   logic cnt_zero;
   logic [fdd_pkg::TIMER_W-1:0] cnt_load;
   logic load;
   assign cnt_zero = (cnt_reg == '0);
   always_comb begin
      state_next = state_reg;
      load = 1'b0;
      cnt_load = '0;
      unique case (state_reg)
         fdd_pkg::H_IDLE: begin
            if (cmd_pend_reg & cmd_reg[fdd_pkg::CMD_STEP]) begin
               state_next = fdd_pkg::H_DIR;
               load = 1'b1;
               cnt_load = fdd_pkg::TIMER_W'(fdd_pkg::DIR_SETTLE_CYC);
            end else if (cmd_pend_reg & cmd_reg[fdd_pkg::CMD_WRITE]) begin
               state_next = fdd_pkg::H_LEAD;
               load = 1'b1;
               cnt_load = fdd_pkg::TIMER_W'(fdd_pkg::GATE_LEAD_CYC);
            end
         end
         fdd_pkg::H_DIR: if (cnt_zero) begin
            state_next = fdd_pkg::H_STEP;
            load = 1'b1;
            cnt_load = fdd_pkg::TIMER_W'(fdd_pkg::STEP_LOW_CYC);
         end
         fdd_pkg::H_STEP: if (cnt_zero) begin
            state_next = fdd_pkg::H_HOLD;
            load = 1'b1;
            cnt_load = fdd_pkg::TIMER_W'(fdd_pkg::DIR_SETTLE_CYC);
         end
         fdd_pkg::H_HOLD: if (cnt_zero) state_next = fdd_pkg::H_IDLE;
         fdd_pkg::H_LEAD: if (cnt_zero) begin
            state_next = fdd_pkg::H_WRITE;
            load = 1'b1;
            cnt_load = fdd_pkg::TIMER_W'(fdd_pkg::ZERO_RATE_CYC);
         end
         fdd_pkg::H_WRITE: if (cnt_zero) begin
            load = 1'b1;
            if (flux_count_reg == 8'h00) begin
               state_next = fdd_pkg::H_LAG;
               cnt_load = fdd_pkg::TIMER_W'(fdd_pkg::GATE_LEAD_CYC);
            end else begin
               cnt_load = fdd_pkg::TIMER_W'(fdd_pkg::ZERO_RATE_CYC);
            end
         end
         fdd_pkg::H_LAG: if (cnt_zero) begin
            state_next = fdd_pkg::H_QUIET;
            load = 1'b1;
            cnt_load = fdd_pkg::TIMER_W'(fdd_pkg::STEP_AFTER_WRITE_CYC);
         end
         fdd_pkg::H_QUIET: if (cnt_zero) state_next = fdd_pkg::H_IDLE;
      endcase
   end
   logic step_n_reg;
   logic gate_n_reg;
   logic flux_n_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= fdd_pkg::H_IDLE;
         cnt_reg <= '0;
         cmd_reg <= 4'h0;
         cmd_pend_reg <= 1'b0;
         flux_count_reg <= 8'h00;
         step_n_reg <= 1'b1;
         gate_n_reg <= 1'b1;
         flux_n_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= load ? cnt_load : (cnt_zero ? cnt_reg : cnt_reg - 1'b1);
         if (wr_cmd) begin
            cmd_reg <= reg_wdata[3:0];
            cmd_pend_reg <= 1'b1;
         end else if (state_reg == fdd_pkg::H_IDLE) begin
            cmd_pend_reg <= 1'b0;
         end
         if (wr_flux) begin
            flux_count_reg <= reg_wdata;
         end else if (state_reg == fdd_pkg::H_WRITE & cnt_zero & flux_count_reg != 8'h00) begin
            flux_count_reg <= flux_count_reg - 8'h01;
         end
         step_n_reg <= ~(state_next == fdd_pkg::H_STEP);
         gate_n_reg <= ~((state_next == fdd_pkg::H_LEAD) | (state_next == fdd_pkg::H_WRITE)
                        | (state_next == fdd_pkg::H_LAG));
         flux_n_reg <= ~((state_reg == fdd_pkg::H_WRITE) &
                         (cnt_reg > fdd_pkg::TIMER_W'(fdd_pkg::ZERO_RATE_CYC -
                          fdd_pkg::FLUX_LOW_CYC)));
      end
   end
   logic dir_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dir_reg <= 1'b1;
      end else if (state_reg == fdd_pkg::H_IDLE & cmd_pend_reg) begin
         dir_reg <= cmd_reg[fdd_pkg::CMD_DIR_OUT];
      end
   end
   assign cable.select_n = ~ctrl_reg[fdd_pkg::CTRL_SELECT];
   assign cable.side_select_n = ~ctrl_reg[fdd_pkg::CTRL_SIDE1];
   assign cable.reduced_current_n = ~ctrl_reg[fdd_pkg::CTRL_REDUCED];
   assign cable.dir_out = dir_reg;
   assign cable.step_n = step_n_reg;
   assign cable.head_write_strobe_n = gate_n_reg;
   assign cable.flux_pulse_input_n = flux_n_reg;
   assign reg_rdata = rdata_reg;
endmodule : fdd_host

//--- verification/cable_rules_sva.sv
// Checker for the drive end of the parallel cable, fed from the interface
module cable_rules_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic select_n,
   input wire logic dir_out,
   input wire logic step_n,
   input wire logic head_write_strobe_n,
   input wire logic flux_pulse_input_n,
   input wire logic reduced_current_n,
   input wire logic side_select_n,
   input wire logic media_protected,
   input wire logic [1:0] phase,
   input wire logic write_current_on,
   input wire logic full_current,
   input wire logic winding_select,
   input wire logic trim_erase_on,
   input wire logic read_enable,
   input wire logic side1_selected
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   int low_cnt;
   // Cycles the write strobe has been held low, saturating
   always_ff @(posedge clk or posedge rst) begin
      if (rst) low_cnt <= 0;
      else if (head_write_strobe_n) low_cnt <= 0;
      else if (low_cnt < 1000000) low_cnt <= low_cnt + 1;
   end
   // --------------------------------------------------------------
   // Stepper
   // --------------------------------------------------------------
   chk_phase_one_bit: assert property ($changed(phase) |-> $countones(phase ^ $past(phase)) == 1)
      else $error("phase moved by more than one bit");
   chk_phase_gated: assert property ($changed(phase) |-> !$past(select_n, 4) && $past(head_write_strobe_n, 4))
      else $error("phase moved while deselected or writing");
   chk_step_on_rise: assert property ($changed(phase) |-> step_n && !$past(step_n, 8))
      else $error("phase moved without a finished step pulse");
   chk_dir_outward: assert property ($changed(phase) && dir_out |-> phase == {~$past(phase[0]), $past(phase[1])})
      else $error("outward step took wrong phase");
   chk_dir_inward: assert property ($changed(phase) && !dir_out |-> phase == {$past(phase[0]), ~$past(phase[1])})
      else $error("inward step took wrong phase");
   // --------------------------------------------------------------
   // Write path, side and trim erase
   // --------------------------------------------------------------
   chk_protect_blocks: assert property (media_protected [*5] |-> !write_current_on)
      else $error("write current on with protected media");
   chk_strobe_needed: assert property (head_write_strobe_n [*5] |-> !write_current_on)
      else $error("write current on without strobe");
   chk_select_needed: assert property (select_n [*5] |-> !write_current_on)
      else $error("write current on while deselected");
   chk_write_starts: assert property ((!head_write_strobe_n && !select_n && !media_protected) [*6] |-> write_current_on)
      else $error("write current missing");
   chk_read_off: assert property (read_enable == !write_current_on)
      else $error("read path not opposite to write current");
   chk_full_level: assert property (reduced_current_n [*5] |-> full_current)
      else $error("full current level not selected");
   chk_reduced_level: assert property (!reduced_current_n [*5] |-> !full_current)
      else $error("reduced current level not selected");
   chk_side_zero: assert property (side_select_n [*5] |-> !side1_selected)
      else $error("side one selected with side line high");
   chk_winding_flux: assert property ($changed(winding_select) |-> !flux_pulse_input_n && $past(flux_pulse_input_n, 8))
      else $error("winding flipped without a flux fall");
   chk_trim_delay: assert property ($rose(trim_erase_on) |-> low_cnt >= fdd_pkg::TRIM_DELAY_CYC)
      else $error("trim erase started early");
   cov_step: cover property ($changed(phase));
   cov_write: cover property ($rose(write_current_on));
   cov_flux: cover property ($changed(winding_select));
endmodule : cable_rules_sva

//--- verification/floppy_drive_step_write_control_bench.sv
// Bench joining host and drive ends, driving the host registers
module floppy_drive_step_write_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic media_protected = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic [1:0] phase;
   logic write_current_on, full_current, winding_select, trim_erase_on, read_enable;
   logic side1_selected;
   int miscompares = 0;
   int n_checks = 0;
   logic [7:0] st;
   fdd_if cable();
   // Clock generation
   always #2 clk = ~clk;
   fdd_host u_fdd_host (.clk(clk), .rst(rst), .cable(cable), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
   fdd_drive u_fdd_drive (.clk(clk), .rst(rst), .cable(cable), .media_protected(media_protected),
      .phase(phase), .write_current_on(write_current_on), .full_current(full_current),
      .winding_select(winding_select), .trim_erase_on(trim_erase_on),
      .read_enable(read_enable), .side1_selected(side1_selected));
   cable_rules_sva u_cable_rules_sva (.clk(clk), .rst(rst), .select_n(cable.select_n),
      .dir_out(cable.dir_out), .step_n(cable.step_n),
      .head_write_strobe_n(cable.head_write_strobe_n),
      .flux_pulse_input_n(cable.flux_pulse_input_n),
      .reduced_current_n(cable.reduced_current_n), .side_select_n(cable.side_select_n),
      .media_protected(media_protected), .phase(phase), .write_current_on(write_current_on),
      .full_current(full_current), .winding_select(winding_select),
      .trim_erase_on(trim_erase_on), .read_enable(read_enable),
      .side1_selected(side1_selected));
   // --------------------------------------------------------------
   // Access and check tasks
   // --------------------------------------------------------------
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask : rd
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wait_idle();
      logic [7:0] s;
      int i;
      s = 8'h01;
      i = 0;
      while (s[0] !== 1'b0 && i < 40000) begin
         rd(fdd_pkg::REG_STATUS, s);
         i++;
      end
      chk("busy", 8'h00, {7'h00, s[0]});
   endtask : wait_idle
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   // Watchdog: two step sequences of about 50k cycles each plus a short write
   initial begin
      repeat (115000) @(posedge clk);
      miscompares++;
      wrap_up();
   end
   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("phase", {6'h00, fdd_pkg::PHASE_0}, {6'h00, phase});
      wr(fdd_pkg::REG_CTRL, 8'h07);
      rd(fdd_pkg::REG_CTRL, st);
      chk("ctrl", 8'h07, st);
      rd(fdd_pkg::REG_STATUS, st);
      chk("index seen", 8'h01, {7'h00, st[1]});
      rd(fdd_pkg::REG_STATUS, st);
      chk("index cleared", 8'h00, {7'h00, st[1]});
      repeat (8) @(negedge clk);
      chk("full current", 8'h00, {7'h00, full_current});
      chk("side one", 8'h01, {7'h00, side1_selected});
      wr(fdd_pkg::REG_CTRL, 8'h01);
      repeat (8) @(negedge clk);
      chk("full current", 8'h01, {7'h00, full_current});
      chk("side one", 8'h00, {7'h00, side1_selected});
      wr(fdd_pkg::REG_CMD, 8'h01);
      wait_idle();
      chk("phase", {6'h00, fdd_pkg::PHASE_1}, {6'h00, phase});
      wr(fdd_pkg::REG_CTRL, 8'h00);
      wr(fdd_pkg::REG_CMD, 8'h03);
      wait_idle();
      chk("phase", {6'h00, fdd_pkg::PHASE_1}, {6'h00, phase});
      wr(fdd_pkg::REG_CTRL, 8'h01);
      wr(fdd_pkg::REG_FLUX, 8'h01);
      wr(fdd_pkg::REG_CMD, 8'h04);
      repeat (20) @(negedge clk);
      chk("write current", 8'h01, {7'h00, write_current_on});
      chk("read enable", 8'h00, {7'h00, read_enable});
      repeat (1000) @(negedge clk);
      chk("winding", 8'h01, {7'h00, winding_select});
      chk("trim erase", 8'h00, {7'h00, trim_erase_on});
      @(posedge clk);
      media_protected <= 1'b1;
      repeat (8) @(negedge clk);
      chk("write current", 8'h00, {7'h00, write_current_on});
      rd(fdd_pkg::REG_STATUS, st);
      chk("protect status", 8'h01, {7'h00, st[2]});
      wrap_up();
   end
endmodule : floppy_drive_step_write_control_bench
